// ==== hw/acc_consts.svh ====
// Register offsets, field positions, reset values and counts of the calibration control bank.
// Assumes inclusion by bare name from the design files.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_OFF_CFG0 10'h050
`define ACC_OFF_CFG1 10'h051
`define ACC_OFF_BACK 10'h057
`define ACC_OFF_PAT 10'h058
`define ACC_OFF_VEC 10'h05a
`define ACC_OFF_STAT 10'h05b
`define ACC_OFF_TCAL 10'h066
`define ACC_RST_CFG0 8'h06
`define ACC_RST_CFG1 8'hf4
`define ACC_RST_BACK 8'h10
`define ACC_RST_PAT 8'h00
`define ACC_RST_TCAL 8'h02
`define ACC_RST_RANGE 3'h7
`define ACC_STAT_RSVD 6'h02
`define ACC_BIT_TSTAMP 5
`define ACC_BIT_VECEN 4
`define ACC_BIT_SWCAL 3
`define ACC_RANGE_HI 6
`define ACC_RANGE_LO 4
`define ACC_BIT_CONT 1
`define ACC_BIT_BCKEN 0
`define ACC_BIT_PATEN 2
`define ACC_BIT_OREN 1
`define ACC_BIT_TAUTO 0
`define ACC_VEC_DEPTH 16
`define ACC_VEC_AW 4
`define ACC_FG_CYCLES 8'd64
`define ACC_TCAL_CYCLES 8'd16
`define ACC_BG_STOP_CYCLES 8'd4
`endif

// ==== hw/acc_pkg.sv ====
// Types shared by the calibration control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package acc_pkg;
	typedef enum logic [2:0] {CAL_IDLE, CAL_TIMING, CAL_FORE, CAL_BACK_RUN, CAL_BACK_STOP} acc_state_t;
endpackage : acc_pkg

// ==== hw/acc_vector_store.sv ====
// Calibration vector store walked by a wrapping index.
// Assumes one read or write strobe per access from the register bank.
`include "acc_consts.svh"
module acc_vector_store import acc_pkg::*; (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Access port.
	input wire logic enable,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData
);
	logic [7:0] mem [`ACC_VEC_DEPTH];
	logic [`ACC_VEC_AW-1:0] idx_q;
	wire step = enable && (wrStb || rdStb);
	assign rdData = enable ? mem[idx_q] : 8'h00;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idx_q <= '0;
		end else if (!enable) begin
			idx_q <= '0;
		end else if (step) begin
			idx_q <= idx_q + 1'b1;
		end
	end
	generate
		for (genvar i = 0; i < `ACC_VEC_DEPTH; i++) begin : g_ent
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					mem[i] <= 8'h00;
				end else if (enable && wrStb && int'(idx_q) == i) begin
					mem[i] <= wrData;
				end
			end
		end
	endgenerate
endmodule : acc_vector_store

// ==== hw/acc_calib_ctrl.sv ====
// Calibration control and status register bank with a small calibration sequencer.
// Assumes a serial-port front end that delivers decoded address, write and read strobes on core_clk.
// The sequencer models only the phase timing of the calibration engine, not its internals.
// Unmapped addresses read as zero and ignore writes; the status register ignores writes.
// All registers and outputs share core_clk, so no crossing logic is needed.
`include "acc_consts.svh"
module acc_calib_ctrl import acc_pkg::*; (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Register access.
	input wire logic [9:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata_q,
	// Time-stamp capture.
	input wire logic timeStampIn,
	output logic timeStamp_q,
	// Sample path.
	input wire logic [11:0] sampleIn,
	input wire logic [11:0] testPattern,
	input wire logic overRangeIn,
	output logic [11:0] sampleOut_q,
	output logic overRangeOut_q,
	// Calibration engine controls.
	output logic [2:0] signalRangeSelect_q,
	output logic calibActive_q
);
	logic [7:0] cfg0_q, cfg1_q, back_q, pat_q, tcal_q;
	logic [7:0] cfg0_d;
	logic [7:0] cfg1_d;
	logic [7:0] back_d;
	logic [7:0] pat_d;
	logic [7:0] tcal_d;
	logic stopped_q, firstDone_q;
	logic stopped_d;
	logic firstDone_d;
	logic calibActive_d;
	logic [7:0] cnt_q, cnt_d;
	acc_state_t state_q, state_d, startState;
	logic [7:0] vecRd;
	logic [7:0] regRdata_d;
	logic timeStamp_d;
	logic [11:0] sampleOut_d;
	logic overRangeOut_d;
	logic [2:0] signalRangeSelect_d;

	// Address decode and access strobes.
	wire selCfg0 = regAddr == `ACC_OFF_CFG0;
	wire selCfg1 = regAddr == `ACC_OFF_CFG1;
	wire selBack = regAddr == `ACC_OFF_BACK;
	wire selPat = regAddr == `ACC_OFF_PAT;
	wire selVec = regAddr == `ACC_OFF_VEC;
	wire selStat = regAddr == `ACC_OFF_STAT;
	wire selTcal = regAddr == `ACC_OFF_TCAL;
	wire wrCfg0 = regWrite && selCfg0;
	wire wrCfg1 = regWrite && selCfg1;
	wire wrBack = regWrite && selBack;
	wire wrPat = regWrite && selPat;
	wire wrTcal = regWrite && selTcal;
	wire wrVec = regWrite && selVec;
	wire rdVec = regRead && selVec;

	// Control fields.
	wire vecEn = cfg0_q[`ACC_BIT_VECEN];
	wire tsEn = cfg0_q[`ACC_BIT_TSTAMP];
	wire patEn = pat_q[`ACC_BIT_PATEN];
	wire orEn = pat_q[`ACC_BIT_OREN];
	wire timingAuto = tcal_q[`ACC_BIT_TAUTO];
	wire contBit = back_q[`ACC_BIT_CONT];
	wire modeBit = back_q[`ACC_BIT_BCKEN];
	wire contOn = contBit && modeBit;
	wire swStart = wrCfg0 && regWdata[`ACC_BIT_SWCAL];
	wire [7:0] swMask = ~(8'h01 << `ACC_BIT_SWCAL);

	// Sequencer helpers.
	wire cntDone = cnt_q == 8'd0;
	wire stateChange = state_d != state_q;
	wire cntReload = stateChange || swStart;
	wire inFore = state_q == CAL_FORE;
	wire nextIdle = state_d == CAL_IDLE;
	wire foreEnd = inFore && state_d != CAL_FORE && !swStart;
	wire [7:0] cntStep = cntDone ? cnt_q : cnt_q - 8'd1;
	wire [7:0] cntLoad = state_d == CAL_TIMING ? `ACC_TCAL_CYCLES :
		state_d == CAL_FORE ? `ACC_FG_CYCLES :
		`ACC_BG_STOP_CYCLES;

	// Read data selection.
	wire [5:0] statRsvd = `ACC_STAT_RSVD;
	wire [7:0] statVal = {statRsvd, stopped_q, firstDone_q};
	wire [7:0] rdMux = selCfg0 ? cfg0_q :
		selCfg1 ? cfg1_q :
		selBack ? back_q :
		selPat ? pat_q :
		selVec ? vecRd :
		selStat ? statVal :
		selTcal ? tcal_q :
		8'h00;

	// Next values of the control registers.
	assign cfg0_d = wrCfg0 ? regWdata & swMask : cfg0_q;
	assign cfg1_d = wrCfg1 ? regWdata : cfg1_q;
	assign back_d = wrBack ? regWdata : back_q;
	assign pat_d = wrPat ? regWdata : pat_q;
	assign tcal_d = wrTcal ? regWdata : tcal_q;

	// Next values of the sequencer state, counter and status flags.
	assign startState = timingAuto ? CAL_TIMING : CAL_FORE;
	assign cnt_d = cntReload ? cntLoad : cntStep;
	assign stopped_d = nextIdle;
	assign calibActive_d = !nextIdle;
	assign firstDone_d = firstDone_q || foreEnd;

	// Next values of the registered outputs.
	assign regRdata_d = regRead ? rdMux : regRdata_q;
	assign timeStamp_d = tsEn && timeStampIn;
	assign sampleOut_d = patEn ? testPattern : sampleIn;
	assign overRangeOut_d = orEn && overRangeIn;
	assign signalRangeSelect_d = cfg1_q[`ACC_RANGE_HI:`ACC_RANGE_LO];

	acc_vector_store u_vec (
		.core_clk(core_clk),
		.rst(rst),
		.enable(vecEn),
		.wrStb(wrVec),
		.rdStb(rdVec),
		.wrData(regWdata),
		.rdData(vecRd)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			CAL_IDLE: begin
				if (contOn) begin
					state_d = CAL_BACK_RUN;
				end
			end
			CAL_TIMING: begin
				if (cntDone) begin
					state_d = CAL_FORE;
				end
			end
			CAL_FORE: begin
				if (cntDone) begin
					state_d = contOn ? CAL_BACK_RUN : CAL_IDLE;
				end
			end
			CAL_BACK_RUN: begin
				if (!contOn) begin
					state_d = CAL_BACK_STOP;
				end
			end
			CAL_BACK_STOP: begin
				if (cntDone) begin
					state_d = CAL_IDLE;
				end
			end
			default: state_d = CAL_IDLE;
		endcase
		if (swStart) begin
			state_d = startState;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= CAL_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'd0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg0_q <= `ACC_RST_CFG0;
		end else begin
			cfg0_q <= cfg0_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg1_q <= `ACC_RST_CFG1;
		end else begin
			cfg1_q <= cfg1_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			back_q <= `ACC_RST_BACK;
		end else begin
			back_q <= back_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pat_q <= `ACC_RST_PAT;
		end else begin
			pat_q <= pat_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tcal_q <= `ACC_RST_TCAL;
		end else begin
			tcal_q <= tcal_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stopped_q <= 1'b1;
		end else begin
			stopped_q <= stopped_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			firstDone_q <= 1'b0;
		end else begin
			firstDone_q <= firstDone_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			calibActive_q <= 1'b0;
		end else begin
			calibActive_q <= calibActive_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdata_q <= 8'h00;
		end else begin
			regRdata_q <= regRdata_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timeStamp_q <= 1'b0;
		end else begin
			timeStamp_q <= timeStamp_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sampleOut_q <= 12'h000;
		end else begin
			sampleOut_q <= sampleOut_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overRangeOut_q <= 1'b0;
		end else begin
			overRangeOut_q <= overRangeOut_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			signalRangeSelect_q <= `ACC_RST_RANGE;
		end else begin
			signalRangeSelect_q <= signalRangeSelect_d;
		end
	end
endmodule : acc_calib_ctrl

// ==== verif/acc_calib_properties.sv ====
// Port checker for the calibration control bank.
// Assumes one clock domain and the bind at the foot of this file.
`include "acc_consts.svh"
module acc_calib_properties (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Register access.
	input wire logic [9:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata_q,
	// Data paths and controls.
	input wire logic timeStampIn,
	input wire logic timeStamp_q,
	input wire logic [11:0] sampleIn,
	input wire logic [11:0] testPattern,
	input wire logic overRangeIn,
	input wire logic [11:0] sampleOut_q,
	input wire logic overRangeOut_q,
	input wire logic [2:0] signalRangeSelect_q,
	input wire logic calibActive_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cfgSh_q;
	logic [1:0] patSh_q;
	wire cfgWr = regWrite && regAddr == `ACC_OFF_CFG0;
	wire rngWr = regWrite && regAddr == `ACC_OFF_CFG1;
	wire patWr = regWrite && regAddr == `ACC_OFF_PAT;
	wire statRd = regRead && regAddr == `ACC_OFF_STAT;
	// Shadow copies of the enable bits that gate the data paths.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfgSh_q <= 2'h0;
			patSh_q <= 2'h0;
		end else begin
			if (cfgWr)
				cfgSh_q <= regWdata[5:4];
			if (patWr)
				patSh_q <= regWdata[2:1];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	ts_copy_a: assert property (timeStamp_q == ($past(cfgSh_q[1]) && $past(timeStampIn)))
		else $error("time stamp copy wrong");
	pat_select_a: assert property (sampleOut_q == ($past(patSh_q[1]) ? $past(testPattern) : $past(sampleIn)))
		else $error("sample select wrong");
	ovr_gate_a: assert property (overRangeOut_q == ($past(patSh_q[0]) && $past(overRangeIn)))
		else $error("over-range gate wrong");
	start_run_a: assert property (cfgWr && regWdata[3] |=> calibActive_q)
		else $error("start did not run");
	start_clear_a: assert property (regRead && regAddr == `ACC_OFF_CFG0 |=> !regRdata_q[3])
		else $error("start bit reads one");
	stop_flag_a: assert property (statRd |=> regRdata_q[1] == !$past(calibActive_q))
		else $error("stopped flag wrong");
	vec_closed_a: assert property (regRead && regAddr == `ACC_OFF_VEC && !cfgSh_q[0] |=> regRdata_q == 8'h00)
		else $error("closed vector port read data");
	range_out_a: assert property (rngWr ##1 !rngWr |=> signalRangeSelect_q == $past(regWdata[6:4], 2))
		else $error("range output wrong");
	cover property (cfgWr && regWdata[3]);
	cover property (regRead && regAddr == `ACC_OFF_VEC && cfgSh_q[0]);
	cover property (patSh_q == 2'h3);
endmodule : acc_calib_properties
bind acc_calib_ctrl acc_calib_properties chk_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
	.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
	.timeStampIn(timeStampIn), .timeStamp_q(timeStamp_q), .sampleIn(sampleIn), .testPattern(testPattern),
	.overRangeIn(overRangeIn), .sampleOut_q(sampleOut_q), .overRangeOut_q(overRangeOut_q),
	.signalRangeSelect_q(signalRangeSelect_q), .calibActive_q(calibActive_q));

// ==== verif/tb_top.sv ====
// Self-checking bench for the calibration control bank.
// Assumes the design files and the checker are compiled first.
`include "acc_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, timeStampIn = 1'b0, overRangeIn = 1'b0;
	logic [9:0] regAddr = 10'h000;
	logic [7:0] regWdata = 8'h00;
	logic [11:0] sampleIn = 12'h000, testPattern = 12'h000;
	logic [7:0] regRdata_q;
	logic timeStamp_q, overRangeOut_q, calibActive_q;
	logic [11:0] sampleOut_q;
	logic [2:0] signalRangeSelect_q;
	int failures = 0;
	int cmp_count = 0;
	acc_calib_ctrl dut_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q), .timeStampIn(timeStampIn),
		.timeStamp_q(timeStamp_q), .sampleIn(sampleIn), .testPattern(testPattern), .overRangeIn(overRangeIn),
		.sampleOut_q(sampleOut_q), .overRangeOut_q(overRangeOut_q),
		.signalRangeSelect_q(signalRangeSelect_q), .calibActive_q(calibActive_q));
	always #50 core_clk = ~core_clk;
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		step(1);
		regWrite = 1'b0;
		step(1);
	endtask : wr
	task automatic rdc(input logic [9:0] a, input logic [7:0] e);
		regAddr = a;
		regRead = 1'b1;
		step(1);
		regRead = 1'b0;
		check(regRdata_q, e);
		step(1);
	endtask : rdc
	// Counts the cycles the sequencer stays busy, starting at one.
	task automatic run_len(input int e);
		int n;
		n = 1;
		while (calibActive_q === 1'b1 && n < 400) begin
			n++;
			step(1);
		end
		check(12'(n), 12'(e));
	endtask : run_len
	task automatic t_reset;
		rdc(`ACC_OFF_CFG0, `ACC_RST_CFG0);
		rdc(`ACC_OFF_CFG1, `ACC_RST_CFG1);
		rdc(`ACC_OFF_BACK, `ACC_RST_BACK);
		rdc(`ACC_OFF_PAT, `ACC_RST_PAT);
		rdc(`ACC_OFF_TCAL, `ACC_RST_TCAL);
		rdc(`ACC_OFF_STAT, 8'h0a);
		rdc(10'h059, 8'h00);
		check(signalRangeSelect_q, 3'h7);
	endtask : t_reset
	task automatic t_fore;
		wr(`ACC_OFF_CFG1, 8'h84);
		check(signalRangeSelect_q, 3'h0);
		// The start follows every settings change; a serial link re-enable lies outside this bank.
		wr(`ACC_OFF_CFG0, 8'h0e);
		step(8);
		wr(`ACC_OFF_CFG0, 8'h0e);
		rdc(`ACC_OFF_STAT, 8'h08);
		rdc(`ACC_OFF_CFG0, 8'h06);
		run_len(`ACC_FG_CYCLES - 3);
		rdc(`ACC_OFF_STAT, 8'h0b);
	endtask : t_fore
	task automatic t_tcal;
		wr(`ACC_OFF_TCAL, 8'h03);
		wr(`ACC_OFF_CFG0, 8'h0e);
		run_len(`ACC_TCAL_CYCLES + `ACC_FG_CYCLES + 2);
		wr(`ACC_OFF_TCAL, 8'h02);
	endtask : t_tcal
	task automatic t_back;
		wr(`ACC_OFF_BACK, 8'h13);
		step(100);
		check(calibActive_q, 1'b1);
		rdc(`ACC_OFF_STAT, 8'h09);
		wr(`ACC_OFF_BACK, 8'h11);
		run_len(`ACC_BG_STOP_CYCLES + 2);
		rdc(`ACC_OFF_STAT, 8'h0b);
		wr(`ACC_OFF_BACK, 8'h10);
	endtask : t_back
	task automatic t_vec;
		wr(`ACC_OFF_CFG0, 8'h16);
		for (int i = 0; i < `ACC_VEC_DEPTH; i++)
			wr(`ACC_OFF_VEC, 8'(i * 8'h1d + 8'h03));
		for (int i = 0; i < `ACC_VEC_DEPTH; i++)
			rdc(`ACC_OFF_VEC, 8'(i * 8'h1d + 8'h03));
		wr(`ACC_OFF_CFG0, 8'h06);
		rdc(`ACC_OFF_VEC, 8'h00);
		wr(`ACC_OFF_STAT, 8'hff);
		rdc(`ACC_OFF_STAT, 8'h0b);
	endtask : t_vec
	task automatic t_path;
		sampleIn = 12'h5a3;
		testPattern = 12'hc3c;
		overRangeIn = 1'b1;
		timeStampIn = 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(`ACC_OFF_PAT, 8'(m * 2));
			wr(`ACC_OFF_CFG0, m[0] ? 8'h26 : 8'h06);
			check(sampleOut_q, m[1] ? 12'hc3c : 12'h5a3);
			check(overRangeOut_q, m[0]);
			check(timeStamp_q, m[0]);
		end
	endtask : t_path
	task automatic end_sim;
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		step(12);
		rst = 1'b0;
		t_reset();
		t_fore();
		t_tcal();
		t_back();
		t_vec();
		t_path();
		end_sim();
	end
	initial begin
		#200000;
		failures++;
		end_sim();
	end
endmodule : tb_top
